/* inc/frame_offset_pkg.sv */
// Package for the frame offset measurement block: register map, field layouts,
// rate codes, measurement states and AXI4-Lite constants.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
package frame_offset_pkg;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_W = ADDR_W - 2;
	localparam int REG_W = 16;

	// Register indexes; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_MODE = 6'h01;
	localparam logic [IDX_W-1:0] IDX_FAR = 6'h02;
	localparam logic [IDX_W-1:0] IDX_CFG1 = 6'h04;
	localparam logic [IDX_W-1:0] IDX_CFG2 = 6'h05;
	localparam logic [IDX_W-1:0] IDX_CFG3 = 6'h06;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h08;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h09;

	// Reset values and padding
	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam logic [DATA_W-REG_W-1:0] UPPER_ZERO = 16'h0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Serial rate codes and the master clock each one needs
	typedef enum logic [1:0] {
		RATE_2M048 = 2'h0, // 4.096 MHz master clock
		RATE_4M096 = 2'h1, // 8.192 MHz master clock
		RATE_8M192 = 2'h2, // 16.384 MHz master clock
		RATE_RSVD = 2'h3
	} rate_e;

	// Last master clock cycle of a frame at each rate
	localparam int OFS_W = 11;
	localparam logic [OFS_W-1:0] FRAME_LAST_2M048 = 11'h1ff;
	localparam logic [OFS_W-1:0] FRAME_LAST_4M096 = 11'h3ff;
	localparam logic [OFS_W-1:0] FRAME_LAST_8M192 = 11'h7ff;

	// Mode register layout
	typedef struct packed {
		logic [12:0] unused;
		logic eval_start_bit;
		rate_e rate_sel;
	} mode_s;

	// Frame alignment result layout
	typedef struct packed {
		logic [2:0] unused;
		logic eval_done_flag;
		logic half_cycle_phase;
		logic [OFS_W-1:0] offset_count;
	} far_s;

	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_MISS = 1;

	// Measurement sequence, Gray coded along the usual path
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_ARM = 2'h1,
		M_MEAS = 2'h3,
		M_DONE = 2'h2
	} meas_e;

endpackage : frame_offset_pkg

/* hdl/frame_offset_measure.sv */
// Frame offset measurement block: rate selection, frame alignment result,
// stream offset configuration registers and a done/miss interrupt.
// Assumes an AXI4-Lite master on mclk, a one-cycle frame_pulse at each
// frame boundary and frame_eval_input synchronous to mclk.
//
// Behaviour
// - Rate code 00/01/10 picks 2.048/4.096/8.192 Mb/s; code 11 is refused.
// - Done flag in bit 12 sets when evaluation ends; offset is then valid.
// - Done flag clears when the start bit falls from one to zero.
// - Bit 11 gives clock phase of the edge; falling edge, rising in GCI.
// - Phase bit extends offset resolution to half a master clock cycle.
`timescale 1ns/1ns
`default_nettype none
module frame_offset_measure
	import frame_offset_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frame_pulse,
	input wire logic frame_eval_input,
	input wire logic gci_mode,
	output logic [1:0] rate_sel,
	output logic [REG_W-1:0] stream_offset_cfg_1,
	output logic [REG_W-1:0] stream_offset_cfg_2,
	output logic [REG_W-1:0] stream_offset_cfg_3,
	output logic irq
);

	// Byte-lane merge of a 16-bit register
	function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
			input logic [DATA_W-1:0] d, input logic [3:0] s);
		logic [REG_W-1:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction : merge16

	// Last master clock cycle of a frame for a rate code
	function automatic logic [OFS_W-1:0] frame_last(input rate_e r);
		logic [OFS_W-1:0] v;
		case (r)
			RATE_2M048: v = FRAME_LAST_2M048;
			RATE_4M096: v = FRAME_LAST_4M096;
			default: v = FRAME_LAST_8M192;
		endcase
		return v;
	endfunction : frame_last

	logic aw_hold_q;
	logic [IDX_W-1:0] aw_idx_q;
	logic w_hold_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [DATA_W-1:0] rdata_q;
	logic wr_fire;
	logic wr_mode;
	logic wr_stat;
	mode_s mode_q;
	mode_s mode_d;
	far_s far_q;
	logic [REG_W-1:0] cfg1_q;
	logic [REG_W-1:0] cfg2_q;
	logic [REG_W-1:0] cfg3_q;
	logic [REG_W-1:0] stat_q;
	logic [REG_W-1:0] mask_q;
	logic start_prev_q;
	logic start_rise;
	logic start_fall;
	logic fe_neg_q;
	logic fe_pos_q;
	logic edge_hi;
	logic edge_lo;
	logic [OFS_W-1:0] cnt_q;
	logic frame_end;
	meas_e state_q;
	logic ev_done;
	logic ev_miss;

	// Write channel handshakes; one write in flight at a time
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_mode = wr_fire && (aw_idx_q == IDX_MODE);
	assign wr_stat = wr_fire && (aw_idx_q == IDX_IRQ_STAT);
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Address and data capture in either order
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aw_hold_q <= 1'b0;
			aw_idx_q <= '0;
			w_hold_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// Write response; unmapped and read-only targets answer SLVERR
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			if (aw_idx_q == IDX_MODE || aw_idx_q == IDX_CFG1 || aw_idx_q == IDX_CFG2 ||
					aw_idx_q == IDX_CFG3 || aw_idx_q == IDX_IRQ_STAT ||
					aw_idx_q == IDX_IRQ_MASK) begin
				bresp_q <= RESP_OKAY;
			end else begin
				bresp_q <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Mode write; a reserved rate code leaves the rate unchanged
	always_comb begin
		mode_d = merge16(mode_q, w_data_q, w_strb_q);
		if (mode_d.rate_sel == RATE_RSVD) begin
			mode_d.rate_sel = mode_q.rate_sel;
		end
	end

	// Software-written registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= REG_RESET;
			cfg1_q <= REG_RESET;
			cfg2_q <= REG_RESET;
			cfg3_q <= REG_RESET;
			mask_q <= REG_RESET;
		end else if (wr_mode) begin
			mode_q <= mode_d;
		end else if (wr_fire) begin
			if (aw_idx_q == IDX_CFG1) begin
				cfg1_q <= merge16(cfg1_q, w_data_q, w_strb_q);
			end else if (aw_idx_q == IDX_CFG2) begin
				cfg2_q <= merge16(cfg2_q, w_data_q, w_strb_q);
			end else if (aw_idx_q == IDX_CFG3) begin
				cfg3_q <= merge16(cfg3_q, w_data_q, w_strb_q);
			end else if (aw_idx_q == IDX_IRQ_MASK) begin
				mask_q <= merge16(mask_q, w_data_q, w_strb_q);
			end
		end
	end

	assign rate_sel = mode_q.rate_sel;
	assign stream_offset_cfg_1 = cfg1_q;
	assign stream_offset_cfg_2 = cfg2_q;
	assign stream_offset_cfg_3 = cfg3_q;

	// Read channel; answer one cycle after the address is taken
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			if (s_axi_araddr[ADDR_W-1:2] == IDX_MODE) begin
				rdata_q <= {UPPER_ZERO, mode_q};
			end else if (s_axi_araddr[ADDR_W-1:2] == IDX_FAR) begin
				rdata_q <= {UPPER_ZERO, far_q};
			end else if (s_axi_araddr[ADDR_W-1:2] == IDX_CFG1) begin
				rdata_q <= {UPPER_ZERO, cfg1_q};
			end else if (s_axi_araddr[ADDR_W-1:2] == IDX_CFG2) begin
				rdata_q <= {UPPER_ZERO, cfg2_q};
			end else if (s_axi_araddr[ADDR_W-1:2] == IDX_CFG3) begin
				rdata_q <= {UPPER_ZERO, cfg3_q};
			end else if (s_axi_araddr[ADDR_W-1:2] == IDX_IRQ_STAT) begin
				rdata_q <= {UPPER_ZERO, stat_q};
			end else if (s_axi_araddr[ADDR_W-1:2] == IDX_IRQ_MASK) begin
				rdata_q <= {UPPER_ZERO, mask_q};
			end else begin
				rdata_q <= '0;
				rresp_q <= RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Start bit transitions
	assign start_rise = mode_q.eval_start_bit && !start_prev_q;
	assign start_fall = !mode_q.eval_start_bit && start_prev_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			start_prev_q <= 1'b0;
		end else begin
			start_prev_q <= mode_q.eval_start_bit;
		end
	end

	// Evaluation input sampled in the clock-high phase end
	always_ff @(negedge mclk or negedge nrst) begin
		if (!nrst) begin
			fe_neg_q <= 1'b1;
		end else begin
			fe_neg_q <= frame_eval_input;
		end
	end

	// Evaluation input sampled at each rising edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fe_pos_q <= 1'b1;
		end else begin
			fe_pos_q <= frame_eval_input;
		end
	end

	// Active edge in the high phase or in the low phase of the clock
	assign edge_hi = gci_mode ? (!fe_pos_q && fe_neg_q) : (fe_pos_q && !fe_neg_q);
	assign edge_lo = gci_mode ? (!fe_neg_q && frame_eval_input) :
			(fe_neg_q && !frame_eval_input);

	// Whole-cycle offset counter from the frame boundary
	assign frame_end = (cnt_q == frame_last(mode_q.rate_sel));
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (frame_pulse || frame_end) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Measurement sequence
	assign ev_done = (state_q == M_MEAS) && !start_fall && (edge_hi || edge_lo);
	assign ev_miss = (state_q == M_MEAS) && !start_fall && !(edge_hi || edge_lo) &&
			frame_end;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= M_IDLE;
		end else if (start_fall) begin
			state_q <= M_IDLE;
		end else begin
			case (state_q)
				M_IDLE: begin
					if (start_rise) begin
						state_q <= M_ARM;
					end
				end
				M_ARM: begin
					if (frame_pulse) begin
						state_q <= M_MEAS;
					end
				end
				M_MEAS: begin
					if (ev_done) begin
						state_q <= M_DONE;
					end
				end
				default: begin
					state_q <= M_DONE;
				end
			endcase
		end
	end

	// Alignment result capture and done flag
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			far_q <= REG_RESET;
		end else if (start_fall) begin
			far_q.eval_done_flag <= 1'b0;
		end else if (ev_done) begin
			far_q.offset_count <= cnt_q;
			far_q.half_cycle_phase <= edge_hi;
			far_q.eval_done_flag <= 1'b1;
		end
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stat_q <= REG_RESET;
		end else begin
			for (int i = 0; i < REG_W; i++) begin
				if ((i == IRQ_DONE && ev_done) || (i == IRQ_MISS && ev_miss)) begin
					stat_q[i] <= 1'b1;
				end else if (wr_stat && w_data_q[i] && w_strb_q[i/8]) begin
					stat_q[i] <= 1'b0;
				end
			end
		end
	end
	assign irq = |(stat_q & mask_q);
endmodule : frame_offset_measure
`default_nettype wire

/* tb/frame_offset_chk.sv */
// Port checker for frame_offset_measure, bound to its top.
// Assumes one clock, mclk, and active-low reset nrst.
`timescale 1ns/1ns
`default_nettype none
module frame_offset_chk
	import frame_offset_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] rate_sel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Write taken whole at one edge, and the mode write among them
	wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic to_mode = wr_go && s_axi_awaddr == 8'h04;
	wire logic [1:0] wcode = s_axi_wdata[1:0];
	a_rate_legal: assert property (rate_sel != 2'h3)
		else $error("Reserved rate code on output");
	a_rate_apply: assert property (to_mode && wcode != 2'h3 |-> ##2 rate_sel == $past(wcode, 2))
		else $error("Rate write not applied");
	a_rate_keep: assert property (to_mode && wcode == 2'h3 |-> ##2 $stable(rate_sel))
		else $error("Reserved rate code accepted");
	a_far_ro: assert property (wr_go && s_axi_awaddr == 8'h08 |-> ##2
		s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
		else $error("Result write not refused");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read address taken while busy");
endmodule : frame_offset_chk
bind frame_offset_measure frame_offset_chk frame_offset_chk_inst (
	.mclk(mclk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .rate_sel(rate_sel));
`default_nettype wire

/* tb/eval_source.sv */
// Model of the frame boundary and evaluation pulse source.
// Assumes mclk is the block clock; edges land in either half-cycle.
`timescale 1ns/1ns
`default_nettype none
module eval_source (
	input wire logic mclk,
	output logic frame_pulse,
	output logic fe
);
	initial begin
		frame_pulse = 1'b0;
		fe = 1'b1;
	end
	// Stray edge, boundary pulse, then active edge n cycles on
	task automatic go(input int n, input bit hi, input bit gci);
		fe <= !gci;
		@(posedge mclk);
		#5 fe = gci;
		#20 fe = !gci;
		@(posedge mclk);
		frame_pulse <= 1'b1;
		@(posedge mclk);
		frame_pulse <= 1'b0;
		repeat (n) @(posedge mclk);
		#(hi ? 5 : 15) fe = gci;
		repeat (2) @(posedge mclk);
		fe <= !gci;
	endtask : go
endmodule : eval_source
`default_nettype wire

/* tb/frame_offset_measure_test.sv */
// Self-checking bench for frame_offset_measure over AXI4-Lite.
// Assumes eval_source makes frame timing; the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module frame_offset_measure_test
	import frame_offset_pkg::*;
;
	logic mclk, nrst, fp, fe, gci_mode, irq, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
	logic [ADDR_W-1:0] awa, ara;
	logic [DATA_W-1:0] wd, rdata, d, v;
	logic [1:0] bresp, rresp, rate_sel, r;
	logic [3:0] ws;
	logic [REG_W-1:0] cfg_out [3];
	int fail_count, samples_checked, cycles, n;
	frame_offset_measure frame_offset_measure_inst (.mclk(mclk), .nrst(nrst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .frame_pulse(fp), .frame_eval_input(fe), .gci_mode(gci_mode),
		.rate_sel(rate_sel), .stream_offset_cfg_1(cfg_out[0]),
		.stream_offset_cfg_2(cfg_out[1]), .stream_offset_cfg_3(cfg_out[2]), .irq(irq));
	eval_source eval_source_inst (.mclk(mclk), .frame_pulse(fp), .fe(fe));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic wrap_up();
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Write; the response is accepted a cycle late
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		bit ad, dd;
		ad = 0;
		dd = 0;
		@(posedge mclk);
		awa <= a;
		wd <= dv;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge mclk);
			ad = ad | awr;
			dd = dd | wr_r;
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end while (!(ad && dd));
		repeat (2) @(posedge mclk);
		br <= 1'b1;
		do @(posedge mclk); while (!bv);
		r = bresp;
		br <= 1'b0;
	endtask : wr
	// Read; the data are accepted two cycles late
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		ara <= a;
		arv <= 1'b1;
		do @(posedge mclk); while (!arr);
		arv <= 1'b0;
		repeat (2) @(posedge mclk);
		rr <= 1'b1;
		do @(posedge mclk); while (!rv);
		d = rdata;
		r = rresp;
		rr <= 1'b0;
	endtask : rd
	// Hang limit
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'ha925));
		{nrst, awv, wv, br, arv, rr, gci_mode, awa, ara, wd} = '0;
		ws = 4'hf;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(8'h10 + 8'(4 * i));
			chk("cfg reset", d, 32'h0);
			v = $urandom;
			wr(8'h10 + 8'(4 * i), v);
			rd(8'h10 + 8'(4 * i));
			chk("cfg read", d, {16'h0, v[15:0]});
			chk("cfg port", cfg_out[i], {16'h0, v[15:0]});
		end
		// Upper byte lane only
		wr(8'h10, 32'h55aa);
		ws <= 4'h2;
		wr(8'h10, 32'h1234);
		ws <= 4'hf;
		rd(8'h10);
		chk("cfg strobe", d, 32'h12aa);
		rd(8'h08);
		chk("result reset", d, 32'h0);
		wr(8'h08, 32'hffff);
		chk("result write", r, RESP_SLVERR);
		rd(8'h3c);
		chk("unmapped", r, RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, 32'(i));
			chk("rate", rate_sel, (i == 3) ? 2'h2 : 2'(i));
		end
		wr(8'h24, 32'h1);
		// Both edge polarities, both half-cycles, random offsets
		for (int i = 0; i < 4; i++) begin
			n = $urandom_range(300, 1);
			gci_mode <= i[1];
			wr(8'h04, 32'h0);
			wr(8'h20, 32'h3);
			rd(8'h08);
			chk("done cleared", d[12], 1'b0);
			chk("irq cleared", irq, 1'b0);
			wr(8'h04, 32'h4);
			eval_source_inst.go(n, i[0], i[1]);
			repeat (3) @(posedge mclk);
			rd(8'h08);
			chk("result", d, {19'h0, 1'b1, i[0], 11'(n)});
			chk("irq raised", irq, 1'b1);
			wr(8'h24, 32'h0);
			chk("irq masked", irq, 1'b0);
			wr(8'h24, 32'h1);
		end
		// Edge more than a 512-cycle frame late: miss, then wrapped offset
		wr(8'h04, 32'h0);
		wr(8'h20, 32'h3);
		wr(8'h04, 32'h4);
		eval_source_inst.go(600, 1'b1, 1'b1);
		repeat (3) @(posedge mclk);
		rd(8'h08);
		chk("wrapped result", d, {19'h0, 1'b1, 1'b1, 11'(600 - 512)});
		rd(8'h20);
		chk("miss status", d, 32'h3);
		wrap_up();
	end
endmodule : frame_offset_measure_test
`default_nettype wire
